// file: rtl/core_irq_defines.vh
// Register indices, field positions, reset values and constants of the core control block
`ifndef CORE_IRQ_DEFINES_VH
`define CORE_IRQ_DEFINES_VH

`define FILE_INDIRECT 8'h00
`define FILE_INDIRECT_B1 8'h80
`define FILE_PC_LOW 8'h02
`define FILE_PC_LOW_B1 8'h82
`define FILE_POINTER 8'h04
`define FILE_POINTER_B1 8'h84
`define FILE_PC_LATCH 8'h0A
`define FILE_PC_LATCH_B1 8'h8A
`define FILE_IRQ_CONTROL 8'h0B
`define FILE_IRQ_CONTROL_B1 8'h8B
`define FILE_PERIPH_FLAG 8'h0C
`define FILE_PERIPH_ENABLE 8'h8C
`define FILE_RESET_CAUSE 8'h8E

`define SEL_RAM 4'h0
`define SEL_INDIRECT 4'h1
`define SEL_PC_LOW 4'h2
`define SEL_POINTER 4'h3
`define SEL_PC_LATCH 4'h4
`define SEL_IRQ_CONTROL 4'h5
`define SEL_PERIPH_FLAG 4'h6
`define SEL_PERIPH_ENABLE 4'h7
`define SEL_RESET_CAUSE 4'h8

`define IC_GLOBAL_EN 7
`define IC_PERIPH_EN 6
`define IC_TIMER_EN 5
`define IC_EXT_EN 4
`define IC_PORT_EN 3
`define IC_TIMER_FLAG 2
`define IC_EXT_FLAG 1
`define IC_PORT_FLAG 0
`define CMP_BIT 6
`define RC_BROWNOUT 0
`define RC_POWER_ON 1
`define RC_WATCHDOG 2
`define RC_MASTER_CLEAR 3

`define IRQ_CONTROL_RESET 8'h00
`define PERIPH_FLAG_RESET 8'h00
`define PERIPH_ENABLE_RESET 8'h00
`define RESET_CAUSE_RESET 8'h00
`define PC_LATCH_RESET 8'h00
`define POINTER_RESET 8'h00
`define PC_RESET 13'h0000
`define IRQ_VECTOR 13'h0004
`define PERIPH_MASK 8'h40
`define RESET_CAUSE_MASK 8'h0F

`endif

// file: rtl/core_irq_pc_stack_indirect.v
// Core control: interrupt registers, reset cause, program counter, return stack, indirect access
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "core_irq_defines.vh"

//
// Notes on behaviour
// - Flags set on their events regardless of any enable bit.
// - Interrupt control register is read/write, holding all non-comparator enables and flags.
// - Interrupt control at 0BH and 8BH with fixed bit order, global enable on top.
// - Comparator enable sits in the peripheral enable register at 8CH.
// - Comparator flag sits in the peripheral flag register at 0CH.
// - Reset cause register at 8Eh tells power-on, master clear, watchdog, brown-out apart.
// - Brown-out bit undefined after power-on; software sets it, cleared means brown-out.
// - With brown-out detect disabled the brown-out bit has no meaning.
// - Program counter 13 bits; upper five reachable only through the high latch.
// - Writing the low byte loads upper counter bits from latch bits 4..0.
// - Call or jump takes counter top two bits from latch bits 4..3.
// - Every reset clears the program counter.
// - Return stack is 8 by 13 bits; its pointer is invisible to software.
// - Push on subroutine call and on interrupt vectoring.
// - Pop into counter on return, return with literal, return from interrupt.
// - Push and pop leave the high latch untouched.
// - Stack wraps circularly; ninth push overwrites the first.
// - No overflow or underflow indication.
// - Indirect data port accesses the location chosen by the pointer register.
// - Pointer at the indirect port itself: read gives 00h, write does nothing.
// - Effective address is bank bit over pointer; bank bit kept clear.
module core_irq_pc_stack_indirect #(
  parameter STACK_DEPTH = 8,
  parameter STACK_PTR_W = 3,
  parameter PC_W = 13,
  parameter FILE_DEPTH = 256
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire core_step,
  input wire core_call,
  input wire core_jump,
  input wire core_return,
  input wire core_return_from_irq,
  input wire core_vector,
  input wire [10:0] core_target,
  input wire timer_overflow_evt,
  input wire ext_pin_evt,
  input wire port_change_evt,
  input wire comparator_evt,
  input wire power_on_evt,
  input wire master_clear_evt,
  input wire watchdog_evt,
  input wire brownout_evt,
  input wire brownout_detect_enable,
  output reg [PC_W-1:0] pc,
  output wire irq_request
);

  // Decodes a file index into the register it selects
  function [3:0] file_sel;
    input [7:0] a;
    begin
      case (a)
        `FILE_INDIRECT, `FILE_INDIRECT_B1: file_sel = `SEL_INDIRECT;
        `FILE_PC_LOW, `FILE_PC_LOW_B1: file_sel = `SEL_PC_LOW;
        `FILE_POINTER, `FILE_POINTER_B1: file_sel = `SEL_POINTER;
        `FILE_PC_LATCH, `FILE_PC_LATCH_B1: file_sel = `SEL_PC_LATCH;
        `FILE_IRQ_CONTROL, `FILE_IRQ_CONTROL_B1: file_sel = `SEL_IRQ_CONTROL;
        `FILE_PERIPH_FLAG: file_sel = `SEL_PERIPH_FLAG;
        `FILE_PERIPH_ENABLE: file_sel = `SEL_PERIPH_ENABLE;
        `FILE_RESET_CAUSE: file_sel = `SEL_RESET_CAUSE;
        default: file_sel = `SEL_RAM;
      endcase
    end
  endfunction

  reg [7:0] irq_control;
  reg [7:0] periph_irq_flag;
  reg [7:0] periph_irq_enable;
  reg [7:0] reset_cause;
  reg [7:0] pc_high_latch;
  reg [7:0] pointer_select;
  reg [PC_W-1:0] ret_stack [0:STACK_DEPTH-1];
  reg [STACK_PTR_W-1:0] stack_ptr;
  // Indices that are no register fall through to plain data bytes
  reg [7:0] file_ram [0:FILE_DEPTH-1];

  // Data-phase state of the pipelined bus
  reg dph_act;
  reg dph_write;
  reg [7:0] dph_idx;
  reg rd_done;

  // Reset-cause strobes and the strap come from the reset circuitry, another domain
  reg [4:0] rst_sync1;
  reg [4:0] rst_sync2;
  reg [3:0] rst_prev;

  wire [3:0] rst_level;
  wire [3:0] rst_pulse;
  wire bod_enabled;
  wire any_reset_evt;
  wire accept;
  wire wr_en;
  wire [3:0] bus_sel;
  wire indirect_bank_bit;
  wire [8:0] eff_addr;
  wire [7:0] file_idx;
  wire [3:0] eff_sel;
  wire [7:0] wdata;
  wire [PC_W-1:0] stack_top;

  reg [7:0] rd_val;
  reg [7:0] next_irq_control;
  reg [7:0] next_periph_irq_flag;
  reg [7:0] next_periph_irq_enable;
  reg [7:0] next_reset_cause;
  reg [7:0] next_pc_high_latch;
  reg [7:0] next_pointer_select;
  reg [PC_W-1:0] next_pc;
  reg [STACK_PTR_W-1:0] next_stack_ptr;
  reg push;

  assign rst_level = rst_sync2[3:0];
  assign bod_enabled = rst_sync2[4];
  // Edge detect so a held cause acts only once
  assign rst_pulse = rst_level & ~rst_prev;
  assign any_reset_evt = |rst_pulse;

  // SEQ and NONSEQ both start a transfer; hsize is not checked
  assign accept = hsel & htrans[1] & hready;
  assign wr_en = ce & dph_act & dph_write & hready;
  // Reads take one wait state so hrdata can come from a flop
  // Stalls while ce is low, else an address phase would be lost
  assign hreadyout = ce & (~dph_act | dph_write | rd_done);
  // No error responses: every index maps to a register or a data byte
  assign hresp = 1'b0;

  assign bus_sel = file_sel(dph_idx);
  assign indirect_bank_bit = 1'b0;
  assign eff_addr = (bus_sel == `SEL_INDIRECT) ? {indirect_bank_bit, pointer_select} : {1'b0, dph_idx};
  assign file_idx = eff_addr[7:0];
  // Decoded again after redirection through the pointer
  assign eff_sel = file_sel(file_idx);
  // Registers are a byte wide; upper write lanes are dropped
  assign wdata = hwdata[7:0];
  // Empty-stack pop wraps to the top slot without notice
  assign stack_top = ret_stack[stack_ptr - 1'b1];

  // Level request; the core decides when to vector
  // interrupt gating
  assign irq_request = irq_control[`IC_GLOBAL_EN] &
    ((irq_control[`IC_TIMER_EN] & irq_control[`IC_TIMER_FLAG]) |
     (irq_control[`IC_EXT_EN] & irq_control[`IC_EXT_FLAG]) |
     (irq_control[`IC_PORT_EN] & irq_control[`IC_PORT_FLAG]) |
     (irq_control[`IC_PERIPH_EN] & periph_irq_enable[`CMP_BIT] & periph_irq_flag[`CMP_BIT]));

  always @*
  begin
    rd_val = 8'h00;
    case (eff_sel)
      `SEL_INDIRECT: rd_val = 8'h00;
      // only the low byte reads back
      `SEL_PC_LOW: rd_val = pc[7:0];
      `SEL_POINTER: rd_val = pointer_select;
      `SEL_PC_LATCH: rd_val = pc_high_latch;
      `SEL_IRQ_CONTROL: rd_val = irq_control;
      `SEL_PERIPH_FLAG: rd_val = periph_irq_flag;
      `SEL_PERIPH_ENABLE: rd_val = periph_irq_enable;
      `SEL_RESET_CAUSE: rd_val = reset_cause;
      `SEL_RAM: rd_val = file_ram[file_idx];
      default: rd_val = 8'h00;
    endcase
  end

  always @*
  begin
    next_irq_control = irq_control;
    next_periph_irq_flag = periph_irq_flag;
    next_periph_irq_enable = periph_irq_enable;
    next_reset_cause = reset_cause;
    next_pc_high_latch = pc_high_latch;
    next_pointer_select = pointer_select;
    if (wr_en)
    begin
      case (eff_sel)
        `SEL_IRQ_CONTROL: next_irq_control = wdata;
        // flags clear only by a zero write
        `SEL_PERIPH_FLAG: next_periph_irq_flag = wdata & `PERIPH_MASK;
        `SEL_PERIPH_ENABLE: next_periph_irq_enable = wdata & `PERIPH_MASK;
        `SEL_RESET_CAUSE: next_reset_cause = wdata & `RESET_CAUSE_MASK;
        `SEL_PC_LATCH: next_pc_high_latch = wdata;
        `SEL_POINTER: next_pointer_select = wdata;
        default: next_pointer_select = pointer_select;
      endcase
    end
    // Core resets drop the enables; pending port-change flag survives
    if (any_reset_evt)
    begin
      next_irq_control = {7'h00, next_irq_control[`IC_PORT_FLAG]};
      next_periph_irq_enable = `PERIPH_ENABLE_RESET;
    end
    // Vectoring masks further interrupts until the return
    if (core_vector)
      next_irq_control[`IC_GLOBAL_EN] = 1'b0;
    else if (core_return_from_irq)
      next_irq_control[`IC_GLOBAL_EN] = 1'b1;
    // set regardless of enables; set beats a same-cycle clear
    if (timer_overflow_evt)
      next_irq_control[`IC_TIMER_FLAG] = 1'b1;
    if (ext_pin_evt)
      next_irq_control[`IC_EXT_FLAG] = 1'b1;
    if (port_change_evt)
      next_irq_control[`IC_PORT_FLAG] = 1'b1;
    if (comparator_evt)
      next_periph_irq_flag[`CMP_BIT] = 1'b1;
    // Power-on bit reads low after its event; brown-out bit only while detection is on
    // reset cause capture
    if (rst_pulse[0])
      next_reset_cause[`RC_POWER_ON] = 1'b0;
    if (rst_pulse[1])
      next_reset_cause[`RC_MASTER_CLEAR] = 1'b1;
    if (rst_pulse[2])
      next_reset_cause[`RC_WATCHDOG] = 1'b1;
    // brown-out bit only tracks events while detection is on
    if (rst_pulse[3] & bod_enabled)
      next_reset_cause[`RC_BROWNOUT] = 1'b0;
  end

  always @*
  begin
    next_pc = pc;
    next_stack_ptr = stack_ptr;
    push = 1'b0;
    // Priority: reset event, vector, call or jump, return, low-byte write, step
    // any reset clears the counter
    if (any_reset_evt)
      next_pc = `PC_RESET;
    else if (core_vector)
    begin
      push = 1'b1;
      next_pc = `IRQ_VECTOR;
    end
    else if (core_call | core_jump)
    begin
      push = core_call;
      next_pc = {pc_high_latch[4:3], core_target};
    end
    else if (core_return | core_return_from_irq)
    begin
      next_pc = stack_top;
      next_stack_ptr = stack_ptr - 1'b1;
    end
    else if (wr_en & (eff_sel == `SEL_PC_LOW))
      // low-byte write loads upper bits from latch
      next_pc = {pc_high_latch[4:0], wdata};
    else if (core_step)
      next_pc = pc + 1'b1;
    if (push)
      next_stack_ptr = stack_ptr + 1'b1;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_sync1 <= 5'h00;
      rst_sync2 <= 5'h00;
      rst_prev <= 4'h0;
    end
    else if (ce)
    begin
      rst_sync1 <= {brownout_detect_enable, brownout_evt, watchdog_evt, master_clear_evt, power_on_evt};
      rst_sync2 <= rst_sync1;
      rst_prev <= rst_level;
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_act <= 1'b0;
      dph_write <= 1'b0;
      dph_idx <= 8'h00;
      rd_done <= 1'b0;
      hrdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (hready)
      begin
        dph_act <= accept;
        dph_write <= hwrite;
        dph_idx <= haddr[9:2];
        rd_done <= 1'b0;
      end
      else if (dph_act & ~dph_write)
      begin
        rd_done <= 1'b1;
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_control <= `IRQ_CONTROL_RESET;
      periph_irq_flag <= `PERIPH_FLAG_RESET;
      periph_irq_enable <= `PERIPH_ENABLE_RESET;
      reset_cause <= `RESET_CAUSE_RESET;
      pc_high_latch <= `PC_LATCH_RESET;
      pointer_select <= `POINTER_RESET;
      pc <= `PC_RESET;
      stack_ptr <= {STACK_PTR_W{1'b0}};
    end
    else if (ce)
    begin
      irq_control <= next_irq_control;
      periph_irq_flag <= next_periph_irq_flag;
      periph_irq_enable <= next_periph_irq_enable;
      reset_cause <= next_reset_cause;
      // latch only changes by software write
      pc_high_latch <= next_pc_high_latch;
      pointer_select <= next_pointer_select;
      pc <= next_pc;
      stack_ptr <= next_stack_ptr;
    end
  end

  // Storage arrays carry no reset; contents are undefined at power-up
  always @(posedge hclk)
  begin
    if (ce)
    begin
      if (push)
        ret_stack[stack_ptr] <= pc;
      // self-pointing writes are dropped since eff_sel is never RAM then
      if (wr_en & (eff_sel == `SEL_RAM))
        file_ram[file_idx] <= wdata;
    end
  end

endmodule // core_irq_pc_stack_indirect

// file: rtl/unused_placeholder_none.v
// Intentionally empty design file slot is not used
`timescale 1ns/1ps

// file: testbench/core_irq_assertions.sv
// Port-level assertions for the core control block
`timescale 1ns/1ps
module core_irq_checker #(
  parameter PC_W = 13
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire core_step,
  input wire core_call,
  input wire core_jump,
  input wire core_return,
  input wire core_return_from_irq,
  input wire core_vector,
  input wire [10:0] core_target,
  input wire [PC_W-1:0] pc,
  input wire irq_request
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire no_branch = !(core_vector | core_call | core_jump | core_return | core_return_from_irq);
  sequence rd_taken;
    ce && hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence wr_taken;
    ce && hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence call_s;
    ce && core_call && !core_vector;
  endsequence
  sequence ret_s;
    ce && core_return && !core_vector && !core_call && !core_jump;
  endsequence
  read_wait_a: assert property (rd_taken |=> !hreadyout)
    else $error("read answered without its wait state");
  write_ready_a: assert property (wr_taken ##1 ce |-> hreadyout)
    else $error("write data phase stalled");
  upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  step_count_a: assert property (ce && core_step && no_branch |=> pc == PC_W'($past(pc) + 1'b1))
    else $error("step did not advance the counter by one");
  jump_target_a: assert property (ce && core_jump && !core_vector && !core_call |=> pc[10:0] == $past(core_target))
    else $error("jump target not loaded");
  vector_entry_a: assert property (ce && core_vector |=> pc == 13'h0004 && !irq_request)
    else $error("vectoring did not reach the vector");
  call_return_a: assert property (call_s ##1 ret_s |=> pc == $past(pc, 2))
    else $error("return did not restore the caller");
endmodule // core_irq_checker
bind core_irq_pc_stack_indirect core_irq_checker #(.PC_W(PC_W)) i_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .core_step(core_step), .core_call(core_call), .core_jump(core_jump), .core_return(core_return),
  .core_return_from_irq(core_return_from_irq), .core_vector(core_vector), .core_target(core_target), .pc(pc),
  .irq_request(irq_request));

// file: testbench/tb.sv
// Self-checking bench for the core control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
  typedef struct packed {logic wr; logic [7:0] idx; logic [7:0] val;} row_t;
  reg hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg core_step = 1'b0, core_call = 1'b0, core_jump = 1'b0, core_return = 1'b0, core_rfi = 1'b0, core_vector = 1'b0;
  reg [10:0] core_target = 11'h000;
  reg [3:0] evt = 4'h0;
  // Bit order matches the reset cause register
  reg [3:0] rst_evt = 4'h0;
  reg bod_en = 1'b1;
  wire hready, hresp, irq_request;
  wire [31:0] hrdata;
  wire [12:0] pc;
  int failures = 0, checks_done = 0;
  reg [7:0] rd;
  reg [12:0] p;
  reg [12:0] saved [0:8];
  row_t rows [11] = '{'{1'b1, 8'h0B, 8'h78}, '{1'b0, 8'h8B, 8'h78}, '{1'b1, 8'h8C, 8'hFF}, '{1'b0, 8'h8C, 8'h40},
    '{1'b1, 8'h04, 8'h20}, '{1'b1, 8'h20, 8'h5A}, '{1'b0, 8'h00, 8'h5A}, '{1'b1, 8'h80, 8'h33},
    '{1'b0, 8'h20, 8'h33}, '{1'b0, 8'h84, 8'h20}, '{1'b1, 8'h0B, 8'h00}};
  bit [3:0] ev [4] = '{4'h4, 4'h8, 4'h1, 4'h2};
  bit [7:0] ex [4] = '{8'h07, 8'h0F, 8'h0E, 8'h0C};
  always #12.5 hclk = ~hclk;
  core_irq_pc_stack_indirect i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .core_step(core_step), .core_call(core_call), .core_jump(core_jump),
    .core_return(core_return), .core_return_from_irq(core_rfi), .core_vector(core_vector), .core_target(core_target),
    .timer_overflow_evt(evt[0]), .ext_pin_evt(evt[1]), .port_change_evt(evt[2]), .comparator_evt(evt[3]),
    .power_on_evt(rst_evt[1]), .master_clear_evt(rst_evt[3]), .watchdog_evt(rst_evt[2]), .brownout_evt(rst_evt[0]),
    .brownout_detect_enable(bod_en), .pc(pc), .irq_request(irq_request));
  task test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task tick(int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bounded so a stuck slave ends the run
  task automatic wait_ready();
    int n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 40)
      begin
        failures++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input bit wr, input [7:0] idx, input [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata[7:0];
  endtask
  task automatic rdchk(string n, input [7:0] idx, input [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(n, e, rd)
  endtask
  initial
  begin
    tick(6);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("pc after reset", 13'h0000, pc)
    rdchk("reset cause", 8'h8E, 8'h00);
    foreach (rows[i])
    begin
      bus(rows[i].wr, rows[i].idx, rows[i].val);
      if (!rows[i].wr) `CHK("table row", rows[i].val, rd)
    end
    evt <= 4'hF;
    tick(1);
    evt <= 4'h0;
    tick(1);
    rdchk("irq flags", 8'h0B, 8'h07);
    rdchk("comparator flag", 8'h0C, 8'h40);
    `CHK("irq gated", 1'b0, irq_request)
    bus(1'b1, 8'h0B, 8'hA7);
    tick(1);
    `CHK("irq timer", 1'b1, irq_request)
    bus(1'b1, 8'h0B, 8'h80);
    tick(1);
    `CHK("irq no periph", 1'b0, irq_request)
    bus(1'b1, 8'h0B, 8'hC0);
    tick(1);
    `CHK("irq periph", 1'b1, irq_request)
    p = pc;
    core_vector <= 1'b1;
    tick(1);
    core_vector <= 1'b0;
    tick(1);
    `CHK("vector pc", 13'h0004, pc)
    core_rfi <= 1'b1;
    tick(1);
    core_rfi <= 1'b0;
    tick(1);
    `CHK("return from irq", p, pc)
    `CHK("flag held", 1'b1, irq_request)
    bus(1'b1, 8'h0C, 8'h00);
    bus(1'b1, 8'h0B, 8'h00);
    tick(1);
    `CHK("irq cleared", 1'b0, irq_request)
    bus(1'b1, 8'h0B, 8'hF8);
    tick(1);
    `CHK("no stale irq", 1'b0, irq_request)
    bus(1'b1, 8'h0A, 8'h1F);
    bus(1'b1, 8'h02, 8'h34);
    tick(1);
    `CHK("pc low write", 13'h1F34, pc)
    rdchk("pc low", 8'h02, 8'h34);
    bus(1'b1, 8'h0A, 8'h08);
    core_jump <= 1'b1;
    core_target <= 11'h123;
    tick(1);
    core_jump <= 1'b0;
    tick(1);
    `CHK("jump pc", 13'h0923, pc)
    for (int k = 0; k < 9; k++)
    begin
      saved[k] = pc;
      core_call <= 1'b1;
      core_target <= 11'(k);
      tick(1);
      core_call <= 1'b0;
      tick(1);
    end
    // Ninth call overwrote the first entry
    for (int k = 8; k > 0; k--)
    begin
      core_return <= 1'b1;
      tick(1);
      core_return <= 1'b0;
      tick(1);
      `CHK("stack pop", saved[k], pc)
    end
    rdchk("latch kept", 8'h0A, 8'h08);
    p = pc;
    core_call <= 1'b1;
    core_target <= 11'h055;
    tick(1);
    core_call <= 1'b0;
    core_return <= 1'b1;
    tick(1);
    core_return <= 1'b0;
    tick(1);
    `CHK("call then return", p, pc)
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b1, 8'h00, 8'h55);
    rdchk("self indirect", 8'h00, 8'h00);
    p = pc;
    ce <= 1'b0;
    core_step <= 1'b1;
    tick(3);
    `CHK("frozen pc", p, pc)
    ce <= 1'b1;
    tick(1);
    core_step <= 1'b0;
    tick(1);
    `CHK("step pc", 13'(p + 1), pc)
    bus(1'b1, 8'h8E, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h02, 8'h11);
      rst_evt <= ev[i];
      tick(6);
      rst_evt <= 4'h0;
      `CHK("pc after reset event", 13'h0000, pc)
      rdchk("reset cause", 8'h8E, ex[i]);
    end
    // Brown-out detection off: the event leaves the bit alone
    bod_en <= 1'b0;
    bus(1'b1, 8'h8E, 8'h01);
    rst_evt <= 4'h1;
    tick(6);
    rst_evt <= 4'h0;
    rdchk("brown-out ignored", 8'h8E, 8'h01);
    bod_en <= 1'b1;
    bus(1'b1, 8'h02, 8'h11);
    hresetn <= 1'b0;
    tick(2);
    `CHK("pc mid-run reset", 13'h0000, pc)
    hresetn <= 1'b1;
    tick(1);
    rdchk("cause after reset", 8'h8E, 8'h00);
    rdchk("control after reset", 8'h0B, 8'h00);
    `CHK("pc after release", 13'h0000, pc)
    test_done();
  end
endmodule // tb
